// >>> mcu_move_branch_exec_test.sv
// self-checking bench for mmb_exec
// assumes mmb_pkg and the checker compiled first
`timescale 1ns/1ns
`default_nettype none
module mcu_move_branch_exec_test
  import mmb_pkg::*;
;
  logic       ref_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0;
  logic       dest_bit = 1'b0, zero_flag, busy, spr_we, stack_we;
  mmb_op_e    op = MMB_OP_NOP;
  logic [7:0] imm = 8'h00, accumulator, spr_wdata;
  logic [8:0] target = 9'h000, program_counter, stack_wdata;
  logic [5:0] reg_addr = 6'h00, pre_addr = 6'h00;
  logic [3:0] spr_sel = 4'h0, spr_addr;
  logic [2:0] stack_pointer, stack_addr;
  int         n_mismatch = 0, num_checks = 0;
  mmb_exec dut_u (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .op_valid        (op_valid),
    .op              (op),
    .imm             (imm),
    .target          (target),
    .spr_sel         (spr_sel),
    .reg_addr        (reg_addr),
    .pre_addr        (pre_addr),
    .dest_bit        (dest_bit),
    .accumulator     (accumulator),
    .program_counter (program_counter),
    .stack_pointer   (stack_pointer),
    .zero_flag       (zero_flag),
    .busy            (busy),
    .spr_we          (spr_we),
    .spr_addr        (spr_addr),
    .spr_wdata       (spr_wdata),
    .stack_we        (stack_we),
    .stack_addr      (stack_addr),
    .stack_wdata     (stack_wdata)
  );
  task automatic chk(logic [15:0] s, logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic run(mmb_op_e o, logic [8:0] v, logic d = 1'b0);
    @(negedge ref_clk);
    op_valid = 1'b0;
    pre_addr = v[5:0];
    @(negedge ref_clk);
    op = o;
    {op_valid, target, dest_bit, imm} = {1'b1, v, d, v[7:0]};
    {spr_sel, reg_addr} = {v[3:0], v[5:0]};
    @(negedge ref_clk);
    op_valid = 1'b0;
  endtask : run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic t_move;
    run(MMB_OP_STORE_ACC, 9'h00a);
    run(MMB_OP_LOAD_IMM, 9'h0a5);
    chk(accumulator, 8'ha5);
    run(MMB_OP_STORE_ACC, 9'h00b);
    chk(accumulator, 8'ha5);
    run(MMB_OP_REG_MOVE, 9'h00a);
    chk({zero_flag, accumulator}, 9'h100);
    run(MMB_OP_REG_MOVE, 9'h00b, 1'b1);
    chk({zero_flag, accumulator}, 9'h000);
    run(MMB_OP_REG_MOVE, 9'h00b);
    chk(accumulator, 8'ha5);
    run(MMB_OP_REG_MOVE, 9'h00a, 1'b1);
    run(MMB_OP_LOAD_IMM, 9'h05a);
    chk(zero_flag, 1'b1);
  endtask : t_move
  task automatic t_spr;
    for (int s = 5; s < 16; s++) begin
      run(MMB_OP_SPR_WRITE, 9'(s));
      chk(spr_we, s > 5);
      if (s > 5) chk({spr_addr, spr_wdata}, {4'(s), 8'h5a});
    end
  endtask : t_spr
  task automatic t_branch;
    @(negedge ref_clk);
    op = MMB_OP_LONG_JUMP;
    {op_valid, target} = {1'b1, 9'h1fe};
    @(negedge ref_clk);
    op = MMB_OP_LOAD_IMM;
    imm = 8'hee;
    chk({busy, stack_we, stack_pointer, program_counter}, 14'h21fe);
    @(negedge ref_clk);
    op_valid = 1'b0;
    chk(accumulator, 8'h5a);
    run(MMB_OP_LONG_CALL, 9'h0aa);
    chk({stack_we, stack_addr, stack_wdata}, 13'h11ff);
    chk({stack_pointer, program_counter}, 12'h2aa);
    run(MMB_OP_LONG_CALL, 9'h1ff);
    chk({stack_addr, stack_wdata, stack_pointer}, 15'h155a);
  endtask : t_branch
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (400) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    t_move();
    t_spr();
    t_branch();
    give_verdict();
  end
endmodule : mcu_move_branch_exec_test
`default_nettype wire

// >>> mmb_exec.sv
// execution of move and long branch instructions
// assumes decoded op and operands held stable for one instruction cycle;
// the data register read address is given one cycle ahead on pre_addr
`timescale 1ns/1ns
`default_nettype none
`include "mmb_params.svh"
module mmb_exec
  import mmb_pkg::*;
#(
  parameter int PCW = 9,
  parameter int SPW = 3,
  parameter int AW  = 6
) (
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  input  wire logic           op_valid,
  input  wire mmb_op_e        op,
  input  wire logic [7:0]     imm,
  input  wire logic [PCW-1:0] target,
  input  wire logic [3:0]     spr_sel,
  input  wire logic [AW-1:0]  reg_addr,
  input  wire logic [AW-1:0]  pre_addr,
  input  wire logic           dest_bit,
  output logic      [7:0]     accumulator,
  output logic      [PCW-1:0] program_counter,
  output logic      [SPW-1:0] stack_pointer,
  output logic                zero_flag,
  output logic                busy,
  output logic                spr_we,
  output logic      [3:0]     spr_addr,
  output logic      [7:0]     spr_wdata,
  output logic                stack_we,
  output logic      [SPW-1:0] stack_addr,
  output logic      [PCW-1:0] stack_wdata
);
  mmb_state_e       state_r, state_nxt;
  logic [7:0]       acc_r, acc_nxt;
  logic [PCW-1:0]   pc_r, pc_nxt;
  logic [SPW-1:0]   sp_r, sp_nxt;
  logic             z_r, z_nxt;
  logic             spr_we_r, spr_we_nxt;
  logic [3:0]       spr_addr_r, spr_addr_nxt;
  logic [7:0]       spr_wdata_r, spr_wdata_nxt;
  logic             stk_we_r, stk_we_nxt;
  logic [SPW-1:0]   stk_addr_r, stk_addr_nxt;
  logic [PCW-1:0]   stk_data_r, stk_data_nxt;
  logic             rf_we;
  logic [7:0]       rf_wdata;
  logic [7:0]       rf_rdata;
  logic             take;

  // operand range check for the special register write
  function automatic logic spr_ok(input logic [3:0] s);
    return (s >= `MMB_SPR_LO) && (s <= `MMB_SPR_HI);
  endfunction : spr_ok

  // address of the following instruction
  function automatic logic [PCW-1:0] pc_step(input logic [PCW-1:0] p);
    return p + PCW'(`MMB_PC_STEP);
  endfunction : pc_step

  mmb_regfile #(.AW(AW), .DW(8)) u_rf (
    .ref_clk (ref_clk),
    .wr_en   (rf_we),
    .wr_addr (reg_addr),
    .wr_data (rf_wdata),
    .rd_addr (pre_addr),
    .rd_data (rf_rdata)
  );

  // an op is taken only outside the bubble cycle
  assign take = op_valid && (state_r == MMB_ST_EXEC);

  // data register write path
  always_comb begin
    rf_we    = 1'b0;
    rf_wdata = acc_r;
    if (take && op == MMB_OP_STORE_ACC) begin
      rf_we    = 1'b1;
      rf_wdata = acc_r;
    end else if (take && op == MMB_OP_REG_MOVE &&
                 dest_bit == `MMB_DEST_REG) begin
      rf_we    = 1'b1;
      rf_wdata = rf_rdata;
    end
  end

  // sequencing: state, program counter, stack push
  always_comb begin
    state_nxt    = MMB_ST_EXEC;
    pc_nxt       = pc_r;
    sp_nxt       = sp_r;
    stk_we_nxt   = 1'b0;
    stk_addr_nxt = stk_addr_r;
    stk_data_nxt = stk_data_r;
    if (take) begin
      unique case (op)
        MMB_OP_LONG_CALL: begin
          stk_we_nxt   = 1'b1;
          stk_addr_nxt = sp_r;
          stk_data_nxt = pc_step(pc_r);
          sp_nxt       = sp_r + `MMB_SP_STEP;
          pc_nxt       = target;
          state_nxt    = MMB_ST_BUBBLE;
        end
        MMB_OP_LONG_JUMP: begin
          pc_nxt    = target;
          state_nxt = MMB_ST_BUBBLE;
        end
        MMB_OP_NOP,
        MMB_OP_SPR_WRITE,
        MMB_OP_LOAD_IMM,
        MMB_OP_STORE_ACC,
        MMB_OP_REG_MOVE: begin
          pc_nxt = pc_step(pc_r);
        end
        default: begin
          pc_nxt = pc_step(pc_r);
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r    <= MMB_ST_EXEC;
      pc_r       <= `MMB_PC_RST;
      sp_r       <= `MMB_SP_RST;
      stk_we_r   <= `MMB_BIT_RST;
      stk_addr_r <= `MMB_SP_RST;
      stk_data_r <= `MMB_PC_RST;
    end else begin
      state_r    <= state_nxt;
      pc_r       <= pc_nxt;
      sp_r       <= sp_nxt;
      stk_we_r   <= stk_we_nxt;
      stk_addr_r <= stk_addr_nxt;
      stk_data_r <= stk_data_nxt;
    end
  end

  // data path: accumulator and zero flag
  always_comb begin
    acc_nxt = acc_r;
    z_nxt   = z_r;
    if (take) begin
      unique case (op)
        MMB_OP_LOAD_IMM: begin
          acc_nxt = imm;
        end
        MMB_OP_STORE_ACC: begin
          acc_nxt = acc_r;
        end
        MMB_OP_REG_MOVE: begin
          if (dest_bit != `MMB_DEST_REG) begin
            acc_nxt = rf_rdata;
          end
          z_nxt = (rf_rdata == `MMB_ZERO8);
        end
        MMB_OP_NOP,
        MMB_OP_SPR_WRITE,
        MMB_OP_LONG_CALL,
        MMB_OP_LONG_JUMP: begin
          acc_nxt = acc_r;
        end
        default: begin
          acc_nxt = acc_r;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_r <= `MMB_ACC_RST;
      z_r   <= `MMB_BIT_RST;
    end else begin
      acc_r <= acc_nxt;
      z_r   <= z_nxt;
    end
  end

  // special register port: strobe, select, data
  always_comb begin
    spr_we_nxt    = 1'b0;
    spr_addr_nxt  = spr_addr_r;
    spr_wdata_nxt = spr_wdata_r;
    if (take && op == MMB_OP_SPR_WRITE) begin
      spr_we_nxt    = spr_ok(spr_sel);
      spr_addr_nxt  = spr_sel;
      spr_wdata_nxt = acc_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      spr_we_r    <= `MMB_BIT_RST;
      spr_addr_r  <= `MMB_SPR_LO;
      spr_wdata_r <= `MMB_ACC_RST;
    end else begin
      spr_we_r    <= spr_we_nxt;
      spr_addr_r  <= spr_addr_nxt;
      spr_wdata_r <= spr_wdata_nxt;
    end
  end

  // outputs straight from registers
  always_comb begin
    accumulator     = acc_r;
    program_counter = pc_r;
    stack_pointer   = sp_r;
    zero_flag       = z_r;
    busy            = (state_r == MMB_ST_BUBBLE);
    spr_we          = spr_we_r;
    spr_addr        = spr_addr_r;
    spr_wdata       = spr_wdata_r;
    stack_we        = stk_we_r;
    stack_addr      = stk_addr_r;
    stack_wdata     = stk_data_r;
  end
endmodule : mmb_exec
`default_nettype wire

// >>> mmb_exec_asserts.sv
// checker on the ports of mmb_exec
// assumes mmb_pkg compiled first; bound into every mmb_exec
`timescale 1ns/1ns
`default_nettype none
module mmb_exec_chk
  import mmb_pkg::*;
#(parameter int PCW = 9, parameter int SPW = 3) (
  input wire logic           ref_clk,
  input wire logic           rst_n,
  input wire logic           op_valid,
  input wire mmb_op_e        op,
  input wire logic [PCW-1:0] target,
  input wire logic [3:0]     spr_sel,
  input wire logic           dest_bit,
  input wire logic [7:0]     accumulator,
  input wire logic [PCW-1:0] program_counter,
  input wire logic [SPW-1:0] stack_pointer,
  input wire logic           zero_flag,
  input wire logic           busy,
  input wire logic           spr_we,
  input wire logic           stack_we,
  input wire logic [SPW-1:0] stack_addr,
  input wire logic [PCW-1:0] stack_wdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic tk;
  assign tk = op_valid && !busy;
  spr_strobe_a: assert property (
    tk && op == MMB_OP_SPR_WRITE |=> spr_we == ($past(spr_sel) >= 4'h6))
    else $error("special write strobe wrong");
  call_push_a: assert property (tk && op == MMB_OP_LONG_CALL |=>
    stack_we && stack_addr == $past(stack_pointer)
    && stack_wdata == $past(program_counter) + 9'h001)
    else $error("call push wrong");
  call_load_a: assert property (tk && op == MMB_OP_LONG_CALL |=>
    busy && program_counter == $past(target))
    else $error("call target wrong");
  bubble_one_a: assert property (busy |=> !busy)
    else $error("bubble too long");
  jump_load_a: assert property (tk && op == MMB_OP_LONG_JUMP |=>
    program_counter == $past(target) && !stack_we && $stable(stack_pointer))
    else $error("jump wrong");
  keep_acc_a: assert property (tk && (op == MMB_OP_STORE_ACC ||
    op == MMB_OP_REG_MOVE && dest_bit) |=> $stable(accumulator))
    else $error("accumulator changed");
  move_zero_a: assert property (tk && op == MMB_OP_REG_MOVE &&
    !dest_bit |=> zero_flag == (accumulator == 8'h00))
    else $error("zero flag wrong");
  flags_kept_a: assert property (
    tk && op != MMB_OP_REG_MOVE |=> $stable(zero_flag))
    else $error("zero flag touched");
endmodule : mmb_exec_chk
bind mmb_exec mmb_exec_chk #(.PCW(PCW), .SPW(SPW)) chk_u (
  .ref_clk         (ref_clk),
  .rst_n           (rst_n),
  .op_valid        (op_valid),
  .op              (op),
  .target          (target),
  .spr_sel         (spr_sel),
  .dest_bit        (dest_bit),
  .accumulator     (accumulator),
  .program_counter (program_counter),
  .stack_pointer   (stack_pointer),
  .zero_flag       (zero_flag),
  .busy            (busy),
  .spr_we          (spr_we),
  .stack_we        (stack_we),
  .stack_addr      (stack_addr),
  .stack_wdata     (stack_wdata)
);
`default_nettype wire

// >>> mmb_params.svh
// constants for the move/branch execution block
// assumes inclusion by bare name from the design files
`ifndef MMB_PARAMS_SVH
`define MMB_PARAMS_SVH
`define MMB_SPR_LO      4'h6
`define MMB_SPR_HI      4'hf
`define MMB_PC_RST      9'h000
`define MMB_ACC_RST     8'h00
`define MMB_SP_RST      3'h0
`define MMB_ZERO8       8'h00
`define MMB_PC_STEP     9'h001
`define MMB_SP_STEP     3'h1
`define MMB_DEST_REG    1'b1
`define MMB_BIT_RST     1'b0
`endif

// >>> mmb_pkg.sv
// types for the move/branch execution block
// assumes mmb_params.svh for numeric constants
`default_nettype none
package mmb_pkg;
  typedef enum logic [2:0] {
    MMB_OP_NOP,
    MMB_OP_SPR_WRITE,
    MMB_OP_LONG_CALL,
    MMB_OP_LONG_JUMP,
    MMB_OP_LOAD_IMM,
    MMB_OP_STORE_ACC,
    MMB_OP_REG_MOVE
  } mmb_op_e;
  typedef enum logic {
    MMB_ST_EXEC,
    MMB_ST_BUBBLE
  } mmb_state_e;
endpackage : mmb_pkg
`default_nettype wire

// >>> mmb_regfile.sv
// data register file, 64 x 8, registered read
// assumes single clock, read address presented one cycle ahead
`timescale 1ns/1ns
`default_nettype none
module mmb_regfile #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input  wire logic          ref_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : mmb_regfile
`default_nettype wire
